/* inc/artf_defs.svh */
`ifndef ARTF_DEFS_SVH
`define ARTF_DEFS_SVH

// Register offsets on the plain register port
`define ARTF_OFS_CONTROL 8'hC8
`define ARTF_OFS_RELOAD_LOW 8'hCA
`define ARTF_OFS_RELOAD_HIGH 8'hCB
`define ARTF_OFS_COUNT_LOW 8'hCC
`define ARTF_OFS_COUNT_HIGH 8'hCD
`define ARTF_OFS_CLOCK_SELECT 8'hE4
`define ARTF_OFS_IRQ_ENABLE 8'hE6

// Control register fields
`define ARTF_CTL_HIGH_OVF 7
`define ARTF_CTL_LOW_OVF 6
`define ARTF_CTL_LOW_OVF_IRQ_EN 5
`define ARTF_CTL_SPLIT 3
`define ARTF_CTL_RUN 2
`define ARTF_CTL_EXT_CLK 0

// Clock select register fields
`define ARTF_CKS_LOW_FAST 0
`define ARTF_CKS_HIGH_FAST 1
`define ARTF_CKS_CAPTURE_EN 2

// Extended interrupt enable register field
`define ARTF_IEN_TIMER 7

// Reset values
`define ARTF_RST_BYTE 8'h00
`define ARTF_RST_BIT 1'b0

// Tick dividers and counter limits
`define ARTF_DIV_SYS 4'hC
`define ARTF_DIV_EXT 3'h7
`define ARTF_BYTE_MAX 8'hFF

`endif

/* inc/artf_pkg.sv */
package artf_pkg;

   typedef logic [7:0] artf_byte_t;

   typedef struct packed {
      // Control register
      logic high_overflow_flag;
      logic low_overflow_flag;
      logic low_overflow_irq_enable;
      logic split_mode_select;
      logic run_control_bit;
      logic external_clock_select;
      // Clock select and interrupt enable bits
      logic low_half_fast_clock_select;
      logic high_half_fast_clock_select;
      logic capture_enable_bit;
      logic timer_irq_enable;
      // Counter and reload bytes
      artf_byte_t count_low_half;
      artf_byte_t count_high_half;
      artf_byte_t reload_low_register;
      artf_byte_t reload_high_register;
      // Tick generation
      logic [3:0] sys_div;
      logic [2:0] ext_div;
      logic ext_sync_a;
      logic ext_sync_b;
      logic ext_prev;
      // Outputs
      artf_byte_t rdata;
      logic irq_request;
   } artf_state_s;

endpackage

/* design/artf_timer.sv */
// Contract
// - 16-bit counter of two separate byte halves
// - Ticks: system clock, /12, synced external /8
// - Split bit zero gives 16-bit auto-reload
// - 16-bit wrap loads both reload bytes
// - 16-bit wrap sets high overflow flag
// - Timer irq enable requests on 16-bit overflow
// - Low irq enable adds low byte wrap request
// - Split one, capture zero: two 8-bit timers
// - Each split half reloads from its byte
// - Split: run gates high half only
// - High half tick per its fast select
// - Low half tick per its fast select
// - Split wraps set their own overflow flags
// - Split: high overflow requests interrupt
// - Split: low irq enable adds low overflow
// - Flags cleared only by software writes
// - Low wrap sets low flag in both modes
// - 16-bit counts only with run; controls reset zero
//
// Chosen here: the strobed register port and the register addresses.
`include "artf_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module artf_timer (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   // External oscillator pin
   input wire logic ext_clock,
   // Interrupt request toward the interrupt controller
   output logic irq_request
);

   artf_pkg::artf_state_s state;
   artf_pkg::artf_state_s next_state;

   logic tick_div12;
   logic tick_ext8;
   logic ext_rise;
   logic tick_low;
   logic tick_high;
   logic low_wrap;
   logic high_wrap;
   logic irq_cond;

   // Prescalers for the slower tick sources
   assign tick_div12 = (state.sys_div == (`ARTF_DIV_SYS - 4'h1));
   // Edge taken after the second synchroniser stage only
   assign ext_rise = state.ext_sync_b & ~state.ext_prev;
   assign tick_ext8 = ext_rise && (state.ext_div == `ARTF_DIV_EXT);

   // Per-half tick selection
   always_comb begin
      if (state.low_half_fast_clock_select) begin
         tick_low = 1'b1;
      end else if (state.external_clock_select) begin
         tick_low = tick_ext8;
      end else begin
         tick_low = tick_div12;
      end
      if (state.high_half_fast_clock_select) begin
         tick_high = 1'b1;
      end else if (state.external_clock_select) begin
         tick_high = tick_ext8;
      end else begin
         tick_high = tick_div12;
      end
   end

   // Wrap events for the counting step of this cycle
   always_comb begin
      low_wrap = 1'b0;
      high_wrap = 1'b0;
      if (!state.split_mode_select) begin
         // Low half's tick drives the whole 16-bit counter
         if (state.run_control_bit && tick_low) begin
            low_wrap = (state.count_low_half == `ARTF_BYTE_MAX);
            high_wrap = low_wrap && (state.count_high_half == `ARTF_BYTE_MAX);
         end
      end else if (!state.capture_enable_bit) begin
         low_wrap = tick_low && (state.count_low_half == `ARTF_BYTE_MAX);
         high_wrap = state.run_control_bit && tick_high
            && (state.count_high_half == `ARTF_BYTE_MAX);
      end
   end

   // High flag requests under the timer enable; low flag also needs its own enable
   assign irq_cond = state.timer_irq_enable && (state.high_overflow_flag
      || (state.low_overflow_irq_enable && state.low_overflow_flag));

   always_comb begin
      next_state = state;

      // Synchroniser and prescalers
      next_state.ext_sync_a = ext_clock;
      next_state.ext_sync_b = state.ext_sync_a;
      next_state.ext_prev = state.ext_sync_b;
      if (tick_div12) begin
         next_state.sys_div = 4'h0;
      end else begin
         next_state.sys_div = state.sys_div + 4'h1;
      end
      if (ext_rise) begin
         next_state.ext_div = state.ext_div + 3'h1;
      end

      // Counting
      if (!state.split_mode_select) begin
         if (state.run_control_bit && tick_low) begin
            if (high_wrap) begin
               next_state.count_low_half = state.reload_low_register;
               next_state.count_high_half = state.reload_high_register;
            end else if (low_wrap) begin
               next_state.count_low_half = 8'h00;
               next_state.count_high_half = state.count_high_half + 8'h01;
            end else begin
               next_state.count_low_half = state.count_low_half + 8'h01;
            end
         end
      end else if (!state.capture_enable_bit) begin
         if (tick_low) begin
            if (low_wrap) begin
               next_state.count_low_half = state.reload_low_register;
            end else begin
               next_state.count_low_half = state.count_low_half + 8'h01;
            end
         end
         if (state.run_control_bit && tick_high) begin
            if (high_wrap) begin
               next_state.count_high_half = state.reload_high_register;
            end else begin
               next_state.count_high_half = state.count_high_half + 8'h01;
            end
         end
      end

      // Register writes; a count write overrides this cycle's step
      if (wr) begin
         if (addr == `ARTF_OFS_CONTROL) begin
            next_state.high_overflow_flag = wdata[`ARTF_CTL_HIGH_OVF];
            next_state.low_overflow_flag = wdata[`ARTF_CTL_LOW_OVF];
            next_state.low_overflow_irq_enable = wdata[`ARTF_CTL_LOW_OVF_IRQ_EN];
            next_state.split_mode_select = wdata[`ARTF_CTL_SPLIT];
            next_state.run_control_bit = wdata[`ARTF_CTL_RUN];
            next_state.external_clock_select = wdata[`ARTF_CTL_EXT_CLK];
         end else if (addr == `ARTF_OFS_RELOAD_LOW) begin
            next_state.reload_low_register = wdata;
         end else if (addr == `ARTF_OFS_RELOAD_HIGH) begin
            next_state.reload_high_register = wdata;
         end else if (addr == `ARTF_OFS_COUNT_LOW) begin
            next_state.count_low_half = wdata;
         end else if (addr == `ARTF_OFS_COUNT_HIGH) begin
            next_state.count_high_half = wdata;
         end else if (addr == `ARTF_OFS_CLOCK_SELECT) begin
            next_state.low_half_fast_clock_select = wdata[`ARTF_CKS_LOW_FAST];
            next_state.high_half_fast_clock_select = wdata[`ARTF_CKS_HIGH_FAST];
            next_state.capture_enable_bit = wdata[`ARTF_CKS_CAPTURE_EN];
         end else if (addr == `ARTF_OFS_IRQ_ENABLE) begin
            next_state.timer_irq_enable = wdata[`ARTF_IEN_TIMER];
         end
      end

      // Hardware set wins over a clearing write in the same cycle
      if (low_wrap) begin
         next_state.low_overflow_flag = 1'b1;
      end
      if (high_wrap) begin
         next_state.high_overflow_flag = 1'b1;
      end

      // Read data stands for the single cycle after the strobe
      next_state.rdata = 8'h00;
      if (rd) begin
         if (addr == `ARTF_OFS_CONTROL) begin
            next_state.rdata[`ARTF_CTL_HIGH_OVF] = state.high_overflow_flag;
            next_state.rdata[`ARTF_CTL_LOW_OVF] = state.low_overflow_flag;
            next_state.rdata[`ARTF_CTL_LOW_OVF_IRQ_EN] = state.low_overflow_irq_enable;
            next_state.rdata[`ARTF_CTL_SPLIT] = state.split_mode_select;
            next_state.rdata[`ARTF_CTL_RUN] = state.run_control_bit;
            next_state.rdata[`ARTF_CTL_EXT_CLK] = state.external_clock_select;
         end else if (addr == `ARTF_OFS_RELOAD_LOW) begin
            next_state.rdata = state.reload_low_register;
         end else if (addr == `ARTF_OFS_RELOAD_HIGH) begin
            next_state.rdata = state.reload_high_register;
         end else if (addr == `ARTF_OFS_COUNT_LOW) begin
            next_state.rdata = state.count_low_half;
         end else if (addr == `ARTF_OFS_COUNT_HIGH) begin
            next_state.rdata = state.count_high_half;
         end else if (addr == `ARTF_OFS_CLOCK_SELECT) begin
            next_state.rdata[`ARTF_CKS_LOW_FAST] = state.low_half_fast_clock_select;
            next_state.rdata[`ARTF_CKS_HIGH_FAST] = state.high_half_fast_clock_select;
            next_state.rdata[`ARTF_CKS_CAPTURE_EN] = state.capture_enable_bit;
         end else if (addr == `ARTF_OFS_IRQ_ENABLE) begin
            next_state.rdata[`ARTF_IEN_TIMER] = state.timer_irq_enable;
         end
      end

      next_state.irq_request = irq_cond;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign rdata = state.rdata;
   assign irq_request = state.irq_request;

endmodule

`default_nettype wire

/* sim/artf_timer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module artf_timer_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   // Pin and request
   input wire logic ext_clock,
   input wire logic irq_request
);
   logic ien;
   logic mapped;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   assign mapped = addr inside {8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hE4, 8'hE6};
   // Shadow of the timer interrupt enable
   always_ff @(posedge clk) begin
      if (reset) begin
         ien <= 1'b0;
      end else if (wr && addr == 8'hE6) begin
         ien <= wdata[7];
      end
   end
   sequence s_reload_wr;
      wr && (addr == 8'hCA || addr == 8'hCB);
   endsequence
   sequence s_same_rd;
      rd && addr == $past(addr, 2);
   endsequence
   a_rdata_idle_zero: assert property (!rd |=> rdata == 8'h00)
      else $error("rdata not zero after idle cycle");
   a_unmapped_read_zero: assert property (rd && !mapped |=> rdata == 8'h00)
      else $error("unmapped read not zero");
   a_reset_quiet: assert property (disable iff (1'b0) reset |=> !irq_request)
      else $error("request during reset");
   a_ctl_unused_zero: assert property (rd && addr == 8'hC8 |=> rdata[4] == 1'b0 && rdata[1] == 1'b0)
      else $error("unused control bits not zero");
   a_clksel_upper_zero: assert property (rd && addr == 8'hE4 |=> rdata[7:3] == 5'h00)
      else $error("clock select upper bits not zero");
   a_irq_needs_enable: assert property (!ien |=> !irq_request)
      else $error("request without timer enable");
   a_irqen_readback: assert property (rd && addr == 8'hE6 |=> rdata == {$past(ien), 7'h00})
      else $error("enable readback wrong");
   a_irq_stays_set: assert property (!wr ##1 irq_request |=> irq_request)
      else $error("request dropped without write");
   a_reload_readback: assert property (s_reload_wr ##2 s_same_rd |=> rdata == $past(wdata, 3))
      else $error("reload readback wrong");
endmodule
bind artf_timer artf_timer_chk u_chk (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata),
   .wr(wr), .rd(rd), .rdata(rdata), .ext_clock(ext_clock), .irq_request(irq_request));
`default_nettype wire

/* sim/artf_timer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module artf_timer_bench;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic ext_clock = 1'b0;
   logic [7:0] rdata;
   logic irq_request;
   logic [7:0] d;
   logic [7:0] e;
   logic [7:0] regs [8] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hE4, 8'hE6, 8'h00};
   int error_cnt = 0;
   int n_checks = 0;
   always #12.5 clk = ~clk;
   artf_timer DUT (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .ext_clock(ext_clock), .irq_request(irq_request));
   task summarize;
      $display("checks=%0d errors=%0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
      n_checks++;
      if (!((got >= lo) === 1'b1 && (got <= hi) === 1'b1)) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
      end
   endtask
   task wreg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task rreg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask
   // Bounded wait; a hang ends the run
   task wait_irq;
      int i;
      for (i = 0; i < 2000 && irq_request !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      if (irq_request !== 1'b1) begin
         error_cnt++;
         summarize;
      end
   endtask
   task t_regs;
      foreach (regs[i]) begin
         rreg(regs[i], d);
         chk(d, 8'h00, 8'h00);
      end
      wreg(8'hC8, 8'hFF);
      rreg(8'hC8, d);
      chk(d, 8'hED, 8'hED);
      wreg(8'hC8, 8'h00);
      wreg(8'hE4, 8'hFF);
      rreg(8'hE4, d);
      chk(d, 8'h07, 8'h07);
      wreg(8'hE6, 8'hFF);
      rreg(8'hE6, d);
      chk(d, 8'h80, 8'h80);
      wreg(8'hCA, 8'hA5);
      rreg(8'hCA, d);
      chk(d, 8'hA5, 8'hA5);
   endtask
   task t_sixteen;
      wreg(8'hE4, 8'h01);
      wreg(8'hCA, 8'h34);
      wreg(8'hCB, 8'h12);
      wreg(8'hCD, 8'hFF);
      wreg(8'hCC, 8'hF0);
      wreg(8'hC8, 8'h04);
      wait_irq;
      rreg(8'hC8, d);
      chk(d, 8'hC4, 8'hC4);
      wreg(8'hC8, 8'h00);
      rreg(8'hCD, d);
      chk(d, 8'h12, 8'h12);
      rreg(8'hCC, e);
      chk(e, 8'h34, 8'h50);
      rreg(8'hCC, d);
      chk(d, e, e);
      chk({7'h00, irq_request}, 8'h00, 8'h00);
   endtask
   task t_split;
      wreg(8'hCD, 8'h55);
      wreg(8'hCA, 8'h80);
      wreg(8'hCC, 8'hFE);
      wreg(8'hC8, 8'h28);
      wait_irq;
      rreg(8'hC8, d);
      chk(d, 8'h68, 8'h68);
      rreg(8'hCD, d);
      chk(d, 8'h55, 8'h55);
      rreg(8'hCC, d);
      chk(d, 8'h80, 8'hA0);
      wreg(8'hE4, 8'h02);
      wreg(8'hCD, 8'h00);
      wreg(8'hC8, 8'h0C);
      repeat (30) @(posedge clk);
      wreg(8'hC8, 8'h08);
      rreg(8'hCD, d);
      chk(d, 8'h1E, 8'h22);
      wreg(8'hCD, 8'hFE);
      wreg(8'hC8, 8'h0C);
      wait_irq;
      rreg(8'hC8, d);
      chk(d, 8'h8C, 8'h8C);
      // Clear first so the old request has dropped before the next wait
      wreg(8'hC8, 8'h08);
      wreg(8'hE4, 8'h01);
      wreg(8'hCD, 8'h00);
      wreg(8'hCC, 8'hF8);
      wreg(8'hC8, 8'h24);
      wait_irq;
      rreg(8'hC8, d);
      chk(d, 8'h64, 8'h64);
      wreg(8'hC8, 8'h00);
   endtask
   task t_prescale;
      wreg(8'hE4, 8'h00);
      wreg(8'hCC, 8'h00);
      wreg(8'hC8, 8'h04);
      repeat (120) @(posedge clk);
      wreg(8'hC8, 8'h00);
      rreg(8'hCC, d);
      chk(d, 8'h09, 8'h0B);
      wreg(8'hCC, 8'h00);
      wreg(8'hC8, 8'h05);
      // 64 rising pin edges, slow enough for the synchroniser
      repeat (128) begin
         repeat (2) @(posedge clk);
         ext_clock <= ~ext_clock;
      end
      repeat (4) @(posedge clk);
      wreg(8'hC8, 8'h01);
      rreg(8'hCC, d);
      chk(d, 8'h07, 8'h08);
   endtask
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      t_regs;
      t_sixteen;
      t_split;
      t_prescale;
      summarize;
   end
endmodule
`default_nettype wire
